// ==== dv/hsr_props.sv ====
// concurrent checks on the host slave pins
`timescale 1ns/1ps
module hsr_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // slave pins
  input wire logic cs_n,
  input wire logic ram_sel_n,
  input wire logic wr,
  input wire logic [1:0] size,
  input wire logic [12:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic big_end,
  input wire logic bus16,
  input wire logic [1:0] bus_mode
);
  logic sel;
  logic eb;
  logic [1:0] bl;
  logic [31:0] bm;
  logic [31:0] wm;
  assign sel = !cs_n || !ram_sel_n;
  // big endian only honoured on a wide bus or bus modes 1 and 2
  assign eb = big_end && (!bus16 || bus_mode == hsr_pkg::BUS_MODE_A ||
    bus_mode == hsr_pkg::BUS_MODE_B);
  assign bl = eb ? ~addr[1:0] : addr[1:0];
  assign bm = 32'hff << {bl, 3'h0};
  assign wm = (eb ^ addr[1]) ? 32'hffff0000 : 32'h0000ffff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_needs_sel: assert property (ack |-> $past(sel))
    else $error("ack without select");
  a_wait_max_seven: assert property ($rose(sel) |-> ##[1:8] ack)
    else $error("slave access waited too long");
  a_word_aligned: assert property (sel && size == hsr_pkg::SZ_WORD
    |-> !addr[0])
    else $error("word access at odd address");
  a_pins_held: assert property (sel && !ack |=> sel && $stable(addr)
    && $stable(wr) && $stable(wdata))
    else $error("pins changed before ack");
  a_release_after: assert property (ack |=> !sel)
    else $error("select not released after ack");
  a_byte_lane: assert property (ack && !wr && size == hsr_pkg::SZ_BYTE
    |-> (rdata & ~bm) == 32'h0)
    else $error("byte read on wrong lane");
  a_word_lane: assert property (ack && !wr && size == hsr_pkg::SZ_WORD
    |-> (rdata & ~wm) == 32'h0)
    else $error("word read on wrong lanes");
  c_write: cover property (ack && wr);
  c_big_read: cover property (ack && !wr && big_end);
  c_ram_sel: cover property (ack && !ram_sel_n);
endmodule : hsr_props

// ==== dv/test_host_slave_ram_endian_port.sv ====
// self-checking bench joining host end and device end
`timescale 1ns/1ps
module test_host_slave_ram_endian_port;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_big = 1'b0, cfg_bus16 = 1'b0, run = 1'b0;
  logic [1:0] cfg_bm = hsr_pkg::BUS_MODE_A;
  logic cmd_valid = 1'b0, cmd_we = 1'b0, cmd_ram = 1'b0;
  logic [1:0] cmd_size = 2'h0;
  logic [12:0] cmd_addr = 13'h0;
  logic [31:0] cmd_wdata = 32'h0;
  logic cmd_ready, rsp_valid, rsp_err;
  logic [31:0] rsp_rdata, scr_rdata, ext_addr, ext_wdata;
  logic scr_req = 1'b0, scr_fetch = 1'b0, scr_we = 1'b0;
  logic [31:0] scr_addr = 32'h0, scr_wdata = 32'h0;
  logic [31:0] ext_rdata = 32'h0;
  logic ext_ack = 1'b0;
  logic scr_ack, ext_req, ext_we;
  logic [1:0] ram_mode;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [31:0] v, w, xv;
  logic [12:0] off;
  int n_errors = 0, compares = 0, n_ext = 0;
  always #25 sys_clk = ~sys_clk;
  hsr_if hsr_if_i ();
  hsr_host hsr_host_i (.sys_clk(sys_clk), .nrst(nrst), .cfg_big(cfg_big),
    .cfg_bus16(cfg_bus16), .cfg_bus_mode(cfg_bm),
    .cfg_ram_mode(ram_mode), .script_running(run),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_we(cmd_we),
    .cmd_ram(cmd_ram), .cmd_size(cmd_size), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .bus(hsr_if_i));
  hsr_dev hsr_dev_i (.sys_clk(sys_clk), .nrst(nrst), .bus(hsr_if_i),
    .scr_req(scr_req), .scr_fetch(scr_fetch), .scr_we(scr_we),
    .scr_addr(scr_addr), .scr_wdata(scr_wdata), .scr_ack(scr_ack),
    .scr_rdata(scr_rdata), .ext_req(ext_req), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ack(ext_ack),
    .ext_rdata(ext_rdata), .ram_mode(ram_mode));
  hsr_props hsr_props_i (.sys_clk(sys_clk), .nrst(nrst),
    .cs_n(hsr_if_i.cs_n), .ram_sel_n(hsr_if_i.ram_sel_n),
    .wr(hsr_if_i.wr), .size(hsr_if_i.size), .addr(hsr_if_i.addr),
    .wdata(hsr_if_i.wdata), .rdata(hsr_if_i.rdata), .ack(hsr_if_i.ack),
    .big_end(hsr_if_i.big_end), .bus16(hsr_if_i.bus16),
    .bus_mode(hsr_if_i.bus_mode));
  // external bus answers each request one cycle later
  always @(posedge sys_clk) begin
    ext_ack <= (ext_req === 1'b1) && !ext_ack;
    ext_rdata <= (ext_req === 1'b1) ? xv : ~ext_rdata;
    if (ext_ack) n_ext++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // oldest note against each answer
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        e = q.pop_front();
        chk({31'h0, rsp_err}, {31'h0, e[32]});
        if (e[33]) chk(rsp_rdata, e[31:0]);
      end
    end
  end
  task automatic acc(input logic we, input logic ram,
      input logic [1:0] sz, input logic [12:0] a, input logic [31:0] d,
      input logic err, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    q.push_back({!we && !err, err, exp});
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_we <= we;
    cmd_ram <= ram;
    cmd_size <= sz;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask : acc
  task automatic scr(input logic f, input logic [31:0] a,
      input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    scr_req <= 1'b1;
    scr_fetch <= f;
    scr_addr <= a;
    do begin
      @(negedge sys_clk);
      n++;
    end while (scr_ack !== 1'b1 && n < 50);
    chk(scr_rdata, exp);
    @(posedge sys_clk);
    scr_req <= 1'b0;
    @(posedge sys_clk);
  endtask : scr
  initial begin
    #(50 * 5000);
    n_errors++;
    wrap_up();
  end
  initial begin
    v = $urandom(32'h69187cea);
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk({30'h0, ram_mode}, 32'h0);
    v = $urandom;
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h0, v, 0, 0);
    acc(0, 0, hsr_pkg::SZ_LONG, 13'h0, 0, 0, v);
    acc(0, 0, hsr_pkg::SZ_LONG, 13'h080, 0, 0, v);
    for (int b = 0; b < 2; b++) begin
      @(posedge sys_clk);
      cfg_big <= b[0];
      for (int i = 0; i < 4; i++)
        acc(0, 0, hsr_pkg::SZ_BYTE, i[12:0], 0, 0,
          v & (32'hff << (8 * (b ? 3 - i : i))));
      for (int i = 0; i < 2; i++)
        acc(0, 0, hsr_pkg::SZ_WORD, 13'(2 * i), 0, 0, v &
          ((b[0] ^ i[0]) ? 32'hffff0000 : 32'h0000ffff));
    end
    @(posedge sys_clk);
    cfg_big <= 1'b0;
    acc(0, 0, hsr_pkg::SZ_WORD, 13'h1, 0, 1, 0);
    acc(0, 1, hsr_pkg::SZ_LONG, 13'h1000, 0, 1, 0);
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h004, 32'h2, 0, 0);
    @(posedge sys_clk);
    run <= 1'b1;
    acc(0, 1, hsr_pkg::SZ_LONG, 13'h010, 0, 1, 0);
    @(posedge sys_clk);
    run <= 1'b0;
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h00c, 32'h0000_0010, 0, 0);
    acc(1, 1, hsr_pkg::SZ_LONG, 13'h014, 32'h5a5a_a5a5, 0, 0);
    acc(0, 1, hsr_pkg::SZ_LONG, 13'h014, 0, 0, 32'h5a5a_a5a5);
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h004, 32'h4, 0, 0);
    chk({30'h0, ram_mode}, 32'h2);
    // index 10h plus scratch word 5 lands on ram word 15h
    acc(0, 1, hsr_pkg::SZ_LONG, 13'h1054, 0, 0, 32'h5a5a_a5a5);
    w = $urandom;
    xv = $urandom;
    off = {1'b0, 10'($urandom), 2'h0};
    acc(1, 1, hsr_pkg::SZ_LONG, 13'h1000 | off, w, 0, 0);
    acc(0, 1, hsr_pkg::SZ_LONG, 13'h1000 | off, 0, 0, w);
    scr(1, {19'h0, off}, w);
    chk(n_ext, 0);
    scr(0, {19'h0, off}, xv);
    chk(n_ext, 1);
    fork
      repeat (4) scr(1, {19'h0, off}, w);
      acc(0, 1, hsr_pkg::SZ_LONG, 13'h1000 | off, 0, 0, w);
    join
    // ram base taken from the shadow register once bit 0 is set
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h008, 32'h0000_5000, 0, 0);
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h004, 32'h5, 0, 0);
    scr(1, 32'h0000_5000 | {19'h0, off}, w);
    chk(n_ext, 1);
    acc(1, 0, hsr_pkg::SZ_LONG, 13'h004, 32'h6, 0, 0);
    acc(0, 1, hsr_pkg::SZ_LONG, off, 0, 0, w);
    acc(0, 0, hsr_pkg::SZ_LONG, 13'h0, 0, 0, v);
    // 16-bit bus: big endian only in bus modes 1 and 2
    @(posedge sys_clk);
    cfg_bus16 <= 1'b1;
    cfg_big <= 1'b1;
    cfg_bm <= 2'h3;
    acc(0, 0, hsr_pkg::SZ_BYTE, 13'h0, 0, 0, v & 32'h0000_00ff);
    @(posedge sys_clk);
    cfg_bm <= hsr_pkg::BUS_MODE_B;
    acc(0, 0, hsr_pkg::SZ_BYTE, 13'h0, 0, 0, v & 32'hff00_0000);
    chk(q.size(), 0);
    wrap_up();
  end
endmodule : test_host_slave_ram_endian_port

// ==== hw/hsr_dev.sv ====
// device end: registers, internal ram, mapping, wait arbitration
`timescale 1ns/1ps
module hsr_dev (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host slave pins
  hsr_if.dev bus,
  // script processor side
  input wire logic scr_req,
  input wire logic scr_fetch,
  input wire logic scr_we,
  input wire logic [31:0] scr_addr,
  input wire logic [31:0] scr_wdata,
  output logic scr_ack,
  output logic [31:0] scr_rdata,
  // external master cycle
  output logic ext_req,
  output logic ext_we,
  output logic [31:0] ext_addr,
  output logic [31:0] ext_wdata,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata,
  // status
  output logic [1:0] ram_mode
);
  typedef enum logic [2:0] {
    HSR_S_IDLE = 3'b001,
    HSR_S_INT = 3'b010,
    HSR_S_EXT = 3'b100
  } hsr_scr_t;

  logic [31:0] mem_q [hsr_pkg::RAM_WORDS]; // RULE_01
  logic [7:0] ctrl_q [4];
  logic [7:0] test5_q;
  logic [31:0] base_q;
  logic [31:0] index_q;
  logic [31:0] scr_bank_q [hsr_pkg::SCR_WORDS];
  hsr_scr_t st_q;
  logic [2:0] wait_q;
  logic done_q;
  logic [31:0] rdata_q;
  logic ack_q;

  // decode of the current host access
  logic big;
  logic [3:0] be;
  logic cyc;
  logic hit_reg;
  logic hit_ram;
  logic [6:0] roff;
  logic [hsr_pkg::RAM_AW-1:0] ram_ix;
  logic host_go;
  logic scr_int;
  logic scr_in_ram;
  logic [31:0] eff_base;
  logic [31:0] lane_bits;
  logic [31:0] reg_word;

  assign lane_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};

  assign ram_mode = test5_q[hsr_pkg::T5_MODE_LO +: 2];
  // 16-bit big endian only in two bus modes
  assign big = bus.big_end && (!bus.bus16 ||
    bus.bus_mode == hsr_pkg::BUS_MODE_A ||
    bus.bus_mode == hsr_pkg::BUS_MODE_B); // RULE_19 RULE_13
  assign be = hsr_pkg::lane_mask(bus.size, bus.addr[1:0], big); // RULE_15 RULE_16 RULE_17 RULE_18
  assign cyc = (!bus.cs_n || !bus.ram_sel_n) && !done_q && !ack_q;
  assign roff = bus.addr[6:0]; // RULE_08

  always_comb begin
    hit_reg = 1'b0;
    hit_ram = 1'b0;
    ram_ix = bus.addr[11:2];
    case (ram_mode)
      hsr_pkg::MODE_IDX: begin
        hit_reg = !bus.cs_n;
        hit_ram = !bus.cs_n && roff >= hsr_pkg::OFF_SCR_LO &&
          roff <= hsr_pkg::OFF_SCR_HI; // RULE_05
        ram_ix = index_q[hsr_pkg::RAM_AW-1:0] +
          {7'h00, roff[4:2]}; // RULE_05
      end
      hsr_pkg::MODE_WIDE: begin
        hit_ram = !bus.cs_n && bus.addr[12]; // RULE_07 RULE_09
        hit_reg = !bus.cs_n && !bus.addr[12]; // RULE_07 RULE_08
      end
      hsr_pkg::MODE_SEP: begin
        hit_ram = !bus.ram_sel_n; // RULE_10
        hit_reg = !bus.cs_n && bus.ram_sel_n; // RULE_10
      end
      default: hit_reg = !bus.cs_n; // RULE_22
    endcase
  end

  // script fetch hits ram when ram is mapped and page matches
  assign eff_base = test5_q[hsr_pkg::T5_BASE_BIT] ? base_q :
    hsr_pkg::RAM_BASE_DEF; // RULE_04
  assign scr_in_ram = ram_mode != hsr_pkg::MODE_OFF &&
    scr_addr[31:12] == eff_base[31:12];
  assign scr_int = st_q == HSR_S_IDLE && scr_req && scr_fetch &&
    scr_in_ram; // RULE_02
  // ram has one port; host waits behind fetches, seven cycles at most
  assign host_go = cyc && (!hit_ram || !scr_int ||
    wait_q == hsr_pkg::MAX_WAIT); // RULE_11

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 3'h0;
    end else if (cyc && hit_ram && !host_go) begin
      wait_q <= wait_q + 3'h1; // RULE_11
    end else begin
      wait_q <= 3'h0;
    end
  end

  // one ack per select; done blocks a repeat until the select drops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ack_q <= host_go;
      if (host_go) begin
        done_q <= 1'b1;
      end else if (bus.cs_n && bus.ram_sel_n) begin
        done_q <= 1'b0;
      end
    end
  end
  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;

  // host writes to ram, byte lanes kept as addressed
  always_ff @(posedge sys_clk) begin
    if (host_go && hit_ram && bus.wr) begin
      for (int b = 0; b < 4; b++) begin
        if (be[b]) begin
          mem_q[ram_ix][8*b +: 8] <= bus.wdata[8*b +: 8]; // RULE_12 RULE_20
        end
      end
    end
  end

  // register writes; scratch bank hidden behind ram in indexed mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        ctrl_q[i] <= 8'h00;
      end
      test5_q <= 8'h00;
      base_q <= 32'h0000_0000;
      index_q <= 32'h0000_0000;
      for (int i = 0; i < hsr_pkg::SCR_WORDS; i++) begin
        scr_bank_q[i] <= 32'h0000_0000;
      end
    end else if (host_go && hit_reg && !hit_ram && bus.wr) begin
      for (int b = 0; b < 4; b++) begin
        if (be[b]) begin
          case (roff[6:2])
            hsr_pkg::OFF_CTRL[6:2]: ctrl_q[b] <= bus.wdata[8*b +: 8];
            hsr_pkg::OFF_TEST5[6:2]: begin
              if (b == 0) begin
                test5_q <= bus.wdata[7:0];
              end
            end
            hsr_pkg::OFF_BASE[6:2]: base_q[8*b +: 8] <= bus.wdata[8*b +: 8];
            hsr_pkg::OFF_INDEX[6:2]: begin
              index_q[8*b +: 8] <= bus.wdata[8*b +: 8];
            end
            default: begin
              if (roff >= hsr_pkg::OFF_SCR_LO &&
                  roff <= hsr_pkg::OFF_SCR_HI) begin
                scr_bank_q[roff[4:2]][8*b +: 8] <= bus.wdata[8*b +: 8];
              end
            end
          endcase
        end
      end
    end
  end

  // register word before lane masking
  always_comb begin
    case (roff[6:2])
      hsr_pkg::OFF_CTRL[6:2]: begin
        reg_word = {ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
      end
      hsr_pkg::OFF_TEST5[6:2]: reg_word = {24'h000000, test5_q};
      hsr_pkg::OFF_BASE[6:2]: reg_word = base_q;
      hsr_pkg::OFF_INDEX[6:2]: reg_word = index_q;
      default: begin
        if (roff >= hsr_pkg::OFF_SCR_LO &&
            roff <= hsr_pkg::OFF_SCR_HI) begin
          reg_word = scr_bank_q[roff[4:2]];
        end else begin
          reg_word = 32'h0000_0000;
        end
      end
    endcase
  end

  // read data: addressed lanes only, the rest zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (host_go) begin
      if (hit_ram) begin
        rdata_q <= mem_q[ram_ix] & lane_bits; // RULE_16
      end else if (hit_reg) begin
        rdata_q <= reg_word & lane_bits; // RULE_16 RULE_17 RULE_18
      end else begin
        rdata_q <= 32'h0000_0000; // RULE_22
      end
    end
  end

  // script side: ram fetches inside, everything else on the host bus
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= HSR_S_IDLE;
      scr_ack <= 1'b0;
      scr_rdata <= 32'h0000_0000;
      ext_req <= 1'b0;
      ext_we <= 1'b0;
      ext_addr <= 32'h0000_0000;
      ext_wdata <= 32'h0000_0000;
    end else begin
      scr_ack <= 1'b0;
      case (st_q)
        HSR_S_IDLE: begin
          if (scr_int && !(cyc && hit_ram && host_go)) begin
            scr_rdata <= mem_q[scr_addr[11:2]]; // RULE_02 RULE_21
            scr_ack <= 1'b1;
            st_q <= HSR_S_INT;
          end else if (scr_req && !scr_int &&
              !(scr_fetch && scr_in_ram)) begin
            ext_req <= 1'b1; // RULE_03 RULE_12
            ext_we <= scr_we;
            ext_addr <= scr_addr; // RULE_21
            ext_wdata <= scr_wdata; // RULE_20
            st_q <= HSR_S_EXT;
          end
        end
        HSR_S_INT: st_q <= HSR_S_IDLE;
        HSR_S_EXT: begin
          if (ext_ack) begin
            ext_req <= 1'b0;
            scr_rdata <= ext_rdata; // RULE_20
            scr_ack <= 1'b1;
            st_q <= HSR_S_INT;
          end
        end
        default: st_q <= HSR_S_IDLE;
      endcase
    end
  end
endmodule : hsr_dev

// ==== hw/hsr_host.sv ====
// host end: turns user commands into chip-select slave cycles
`timescale 1ns/1ps
module hsr_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // board straps
  input wire logic cfg_big,
  input wire logic cfg_bus16,
  input wire logic [1:0] cfg_bus_mode,
  input wire logic [1:0] cfg_ram_mode,
  input wire logic script_running,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_we,
  input wire logic cmd_ram,
  input wire logic [1:0] cmd_size,
  input wire logic [12:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  // answer port
  output logic rsp_valid,
  output logic rsp_err,
  output logic [31:0] rsp_rdata,
  // device pins
  hsr_if.host bus
);
  typedef enum logic [1:0] {
    HSR_H_IDLE = 2'b01,
    HSR_H_BUS = 2'b10
  } hsr_host_t;

  hsr_host_t st_q;
  logic cs_n_q;
  logic ram_n_q;
  logic wr_q;
  logic [1:0] size_q;
  logic [12:0] addr_q;
  logic [31:0] wdata_q;
  logic bad;

  assign bus.big_end = cfg_big; // RULE_13
  assign bus.bus16 = cfg_bus16;
  assign bus.bus_mode = cfg_bus_mode;
  assign bus.cs_n = cs_n_q;
  assign bus.ram_sel_n = ram_n_q;
  assign bus.wr = wr_q;
  assign bus.size = size_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign cmd_ready = st_q == HSR_H_IDLE;

  // refuse misaligned words, indexed ram while running, unmapped ram
  assign bad = (cmd_size == hsr_pkg::SZ_WORD && cmd_addr[0]) || // RULE_14
    (cmd_ram && cfg_ram_mode == hsr_pkg::MODE_IDX &&
     script_running) || // RULE_06
    (cmd_ram && cfg_ram_mode == hsr_pkg::MODE_OFF); // RULE_22

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= HSR_H_IDLE;
      cs_n_q <= 1'b1;
      ram_n_q <= 1'b1;
      wr_q <= 1'b0;
      size_q <= hsr_pkg::SZ_BYTE;
      addr_q <= 13'h0000;
      wdata_q <= 32'h0000_0000;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        HSR_H_IDLE: begin
          if (cmd_valid && bad) begin
            rsp_valid <= 1'b1;
            rsp_err <= 1'b1;
          end else if (cmd_valid) begin
            rsp_err <= 1'b0;
            wr_q <= cmd_we;
            size_q <= cmd_size;
            wdata_q <= cmd_wdata;
            st_q <= HSR_H_BUS;
            if (cmd_ram && cfg_ram_mode == hsr_pkg::MODE_SEP) begin
              ram_n_q <= 1'b0; // RULE_10
              addr_q <= {1'b0, cmd_addr[11:0]};
            end else if (cmd_ram && cfg_ram_mode == hsr_pkg::MODE_WIDE) begin
              cs_n_q <= 1'b0; // RULE_07 RULE_09
              addr_q <= hsr_pkg::RAM_WIN | {1'b0, cmd_addr[11:0]};
            end else begin
              cs_n_q <= 1'b0; // RULE_05
              addr_q <= cmd_addr;
            end
          end
        end
        HSR_H_BUS: begin
          if (bus.ack) begin
            cs_n_q <= 1'b1;
            ram_n_q <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_rdata <= bus.rdata;
            st_q <= HSR_H_IDLE;
          end
        end
        default: st_q <= HSR_H_IDLE;
      endcase
    end
  end
endmodule : hsr_host

// ==== hw/hsr_if.sv ====
// slave access pins between host master and device
`timescale 1ns/1ps
interface hsr_if;
  logic cs_n;
  logic ram_sel_n;
  logic wr;
  logic [1:0] size;
  logic [12:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic big_end;
  logic bus16;
  logic [1:0] bus_mode;
  modport host (output cs_n, ram_sel_n, wr, size, addr, wdata, big_end,
    bus16, bus_mode, input rdata, ack);
  modport dev (input cs_n, ram_sel_n, wr, size, addr, wdata, big_end,
    bus16, bus_mode, output rdata, ack);
endinterface : hsr_if

// ==== hw/hsr_pkg.sv ====
// constants, codes and lane decode for the host slave ram port
// Contract
// RULE_01: internal memory is 1K words of 32 bits
// RULE_02: ram fetches served inside, no host cycle
// RULE_03: other device ram accesses go external
// RULE_04: base from ram_base_shadow_reg when ctrl bit0
// RULE_05: mode 01 maps ram through index register
// RULE_06: host avoids indexed ram while script runs
// RULE_07: mode 10 widens cs to regs and ram
// RULE_08: regs at 00-7f, aliased every 128 bytes
// RULE_09: widened mode ram at 1000h to 1fffh
// RULE_10: mode 11 ram on ram select pin only
// RULE_11: host ram access waits at most seven cycles
// RULE_12: script writes reach ram in every mode; the code always sends script writes out on ext_req, never into mem_q
// RULE_13: mode pin picks orientation, lanes unchanged
// RULE_14: byte, word, long; words word aligned
// RULE_15: longwords need no byte repositioning
// RULE_16: word/byte decode keeps registers on lanes
// RULE_17: big endian lane 31-24 is offset 0
// RULE_18: little endian lane 7-0 is offset 0
// RULE_19: 16-bit big endian only bus modes 1, 2
// RULE_20: transfer data bytes keep ascending order
// RULE_21: script register addressing ignores bus mode
// RULE_22: mode 00 keeps ram out of host map
package hsr_pkg;
  localparam int RAM_WORDS = 1024;
  localparam int RAM_AW = 10;
  localparam int ADDR_W = 13;
  // register offsets inside the 128-byte block
  localparam logic [6:0] OFF_CTRL = 7'h00;
  localparam logic [6:0] OFF_TEST5 = 7'h04;
  localparam logic [6:0] OFF_BASE = 7'h08;
  localparam logic [6:0] OFF_INDEX = 7'h0c;
  localparam logic [6:0] OFF_SCR_LO = 7'h10;
  localparam logic [6:0] OFF_SCR_HI = 7'h2f;
  localparam int SCR_WORDS = 8;
  localparam logic [12:0] RAM_WIN = 13'h1000;
  localparam logic [31:0] RAM_BASE_DEF = 32'h0000_0000;
  localparam logic [2:0] MAX_WAIT = 3'h7;
  // chip_test_five_ctrl fields
  localparam int T5_BASE_BIT = 0;
  localparam int T5_MODE_LO = 1;
  // mode = {bit2, bit1}
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_IDX = 2'h1;
  localparam logic [1:0] MODE_WIDE = 2'h2;
  localparam logic [1:0] MODE_SEP = 2'h3;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] BUS_MODE_A = 2'h1;
  localparam logic [1:0] BUS_MODE_B = 2'h2;

  // byte lanes touched by an access; lanes never move, address does
  function automatic logic [3:0] lane_mask(input logic [1:0] size,
      input logic [1:0] a, input logic big);
    logic [1:0] l;
    l = big ? ~a : a;
    case (size)
      SZ_LONG: lane_mask = 4'hf;
      SZ_WORD: lane_mask = (big ^ a[1]) ? 4'hc : 4'h3;
      default: lane_mask = 4'h1 << l;
    endcase
  endfunction : lane_mask
endpackage : hsr_pkg
